// ===== hdl/tcp_pkg.sv
/*
 * constants, defaults and types shared by the transmit message
 * communication-parameter block and its trigger units.
 * assumes a 200 MHz core clock; all values are plain localparams.
 */
package tcp_pkg;

    // ************************************************************
    // object addresses
    // ************************************************************
    localparam logic [15:0] IDX_IDENTITY = 16'h1018;
    localparam logic [15:0] IDX_COMM_BASE = 16'h1800;
    localparam logic [15:0] IDX_MAP_BASE = 16'h1a00;
    localparam logic [7:0] SUB_VENDOR = 8'h01;
    localparam logic [7:0] SUB_PRODUCT = 8'h02;
    localparam logic [7:0] SUB_REVISION = 8'h03;
    localparam logic [7:0] SUB_COBID = 8'h01;
    localparam logic [7:0] SUB_TYPE = 8'h02;
    localparam logic [7:0] SUB_MAP1 = 8'h01;

    // ************************************************************
    // identifier word layout and defaults
    // ************************************************************
    localparam int NUM_MSG = 3;
    localparam int NODE_W = 7;
    localparam int CYC_W = 16;
    localparam int BIT_INVALID = 31;
    localparam int BIT_NO_RTR = 30;
    localparam int BIT_EXT = 29;
    localparam int BASE_ID_W = 11;
    localparam int EXT_ID_W = 29;
    localparam logic [NUM_MSG-1:0][31:0] COBID_DEF = {
        32'hc000_0380, 32'h4000_0280, 32'h4000_0180};
    localparam logic [NUM_MSG-1:0][7:0] TYPE_DEF = {8'h01, 8'h01, 8'hfe};
    localparam logic [31:0] MAP_POSITION = 32'h6004_0020;

    // ************************************************************
    // transmission types and abort codes
    // ************************************************************
    localparam logic [7:0] TYPE_NEVER = 8'h00;
    localparam logic [7:0] TYPE_SYNC_MIN = 8'h01;
    localparam logic [7:0] TYPE_SYNC_MAX = 8'hf0;
    localparam logic [7:0] TYPE_TIMER = 8'hfe;
    localparam logic [31:0] ABORT_RANGE = 32'h0609_0030;
    localparam logic [31:0] ABORT_NO_OBJECT = 32'h0602_0000;
    localparam logic [31:0] ABORT_READ_ONLY = 32'h0601_0002;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int CYC_UNIT_NS = 1000000;
    localparam int CYC_UNIT_CYCLES = CYC_UNIT_NS / CLK_PERIOD_PS * 1000;

    typedef enum logic [1:0] {
        ST_SETTLE_A = 2'b00,
        ST_SETTLE_B = 2'b01,
        ST_LOAD = 2'b10,
        ST_RUN = 2'b11
    } tcp_init_t;

endpackage

// ===== hdl/tcp_top.sv
/*
 * transmit message communication parameters: identity entries,
 * identifier words and trigger types of three transmit messages,
 * object access port and per-message transmit requests.
 * assumes the object port, node id, stored words, sync pulse and
 * cyclic time come from logic on CLOCK_IN; the switches are pins.
 */
// Function
// RULE_01 - identity entries at subs 01, 02, 03 read back, writes refused
// RULE_02 - identifier bit 31 set means message absent, never transmitted
// RULE_03 - master always writes bit 30 as one; remote requests never served
// RULE_04 - identifier bit 29 picks base or extended frame format
// RULE_05 - bits 10..0 low id; bits 28..11 upper id only in extended format
// RULE_06 - timed position message defaults to 4000_0180h plus node address
// RULE_07 - sync position message A defaults to 4000_0280h plus node address
// RULE_08 - sync position message B defaults to c000_0380h plus node, disabled
// RULE_09 - any switch high at power-on forces every identifier to its default
// RULE_10 - all switches low keeps stored identifiers unless address set forced
// RULE_11 - types 01h..f0h send once every n sync frames
// RULE_12 - type feh is timer-driven; timed position message defaults to it
// RULE_13 - type zero is stored but the message never goes out
// RULE_14 - other unsupported types aborted with 0609_0030h, value kept
// RULE_15 - timer mode repeats at the cyclic time; zero time sends nothing
// RULE_16 - sync position message A defaults to type 01h
// RULE_17 - timed message on timer, both sync messages on sync by default
// RULE_18 - default mapping of all three is the position entry 6004_0020h
// RULE_19 - sync count restarts whenever the transmission type is rewritten
`timescale 1ns/1ps
module tcp_top #(
    parameter logic [31:0] VENDOR_CODE = 32'h0000_5a5a,   // arbitrary value
    parameter logic [31:0] PRODUCT_CODE = 32'h0000_0a11,  // arbitrary value
    parameter logic [31:0] REVISION_CODE = 32'h0000_0003, // arbitrary value
    parameter int CYC_UNIT_CYCLES = tcp_pkg::CYC_UNIT_CYCLES
) (
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    input wire logic [tcp_pkg::NODE_W-1:0] NODE_SW_IN,
    input wire logic [tcp_pkg::NODE_W-1:0] NODE_ID_IN,
    input wire logic ADDR_FORCE_IN,
    input wire logic [31:0] STORED_ID_TIMED_POSITION_IN,
    input wire logic [31:0] STORED_ID_SYNC_POSITION_A_IN,
    input wire logic [31:0] STORED_ID_SYNC_POSITION_B_IN,
    input wire logic SYNC_RX_IN,
    input wire logic [tcp_pkg::CYC_W-1:0] CYCLIC_TIME_IN,
    input wire logic OD_REQ_IN,
    input wire logic OD_WR_IN,
    input wire logic [15:0] OD_INDEX_IN,
    input wire logic [7:0] OD_SUB_IN,
    input wire logic [31:0] OD_WDATA_IN,
    output logic OD_READY_OUT,
    output logic OD_ACK_OUT,
    output logic OD_ABORT_OUT,
    output logic [31:0] OD_ABORT_CODE_OUT,
    output logic [31:0] OD_RDATA_OUT,
    output logic [tcp_pkg::NUM_MSG-1:0] TX_REQ_OUT,
    output logic [tcp_pkg::NUM_MSG-1:0] TX_EXT_OUT,
    output logic [28:0] TX_MSG_TIMED_POSITION_ID_OUT,
    output logic [28:0] TX_MSG_SYNC_POSITION_A_ID_OUT,
    output logic [28:0] TX_MSG_SYNC_POSITION_B_ID_OUT
);

    localparam int N = tcp_pkg::NUM_MSG;
    localparam int NW = tcp_pkg::NODE_W;
    localparam int TW = $clog2(CYC_UNIT_CYCLES);
    localparam int EW = tcp_pkg::EXT_ID_W;
    localparam int BW = tcp_pkg::BASE_ID_W;

    // ************************************************************
    // switch synchroniser and power-on load sequence
    // ************************************************************
    logic [NW-1:0] sw_meta_r;
    logic [NW-1:0] sw_sync_r;
    tcp_pkg::tcp_init_t state_r;
    tcp_pkg::tcp_init_t state_nxt;

    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            sw_meta_r <= '0;
            sw_sync_r <= '0;
        end else begin
            sw_meta_r <= NODE_SW_IN;
            sw_sync_r <= sw_meta_r;
        end
    end

    // two settle states let the synchronised switches reach sw_sync_r
    always_comb begin
        case (state_r)
            tcp_pkg::ST_SETTLE_A: state_nxt = tcp_pkg::ST_SETTLE_B;
            tcp_pkg::ST_SETTLE_B: state_nxt = tcp_pkg::ST_LOAD;
            tcp_pkg::ST_LOAD: state_nxt = tcp_pkg::ST_RUN;
            tcp_pkg::ST_RUN: state_nxt = tcp_pkg::ST_RUN;
            default: state_nxt = tcp_pkg::ST_SETTLE_A;
        endcase
    end

    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            state_r <= tcp_pkg::ST_SETTLE_A;
        end else begin
            state_r <= state_nxt;
        end
    end

    wire sw_any = (sw_sync_r != '0);
    wire use_default = sw_any || ADDR_FORCE_IN; // [RULE_09] [RULE_10]
    wire [NW-1:0] node_sel = sw_any ? sw_sync_r : NODE_ID_IN;
    wire running = (state_r == tcp_pkg::ST_RUN);
    wire od_take = OD_REQ_IN && running;
    wire [31:0] stored_w [N];
    assign stored_w[0] = STORED_ID_TIMED_POSITION_IN;
    assign stored_w[1] = STORED_ID_SYNC_POSITION_A_IN;
    assign stored_w[2] = STORED_ID_SYNC_POSITION_B_IN;

    // ************************************************************
    // unit tick for the cyclic timers
    // ************************************************************
    // one shared prescaler keeps the three timers in step and small
    logic [TW-1:0] tick_cnt_r;
    logic unit_tick_r;
    wire tick_wrap = (tick_cnt_r == TW'(CYC_UNIT_CYCLES - 1));

    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            tick_cnt_r <= '0;
            unit_tick_r <= 1'b0;
        end else begin
            tick_cnt_r <= tick_wrap ? '0 : TW'(tick_cnt_r + 1'b1);
            unit_tick_r <= tick_wrap;
        end
    end

    // ************************************************************
    // per-message parameters and triggers
    // ************************************************************
    logic [31:0] cobid_r [N];
    logic [7:0] type_r [N];
    logic [28:0] tx_id_r [N];
    logic [N-1:0] tx_ext_r;
    logic [N-1:0] hit_comm;
    logic [N-1:0] hit_map;
    logic [N-1:0] wr_cobid;
    logic [N-1:0] wr_type;
    logic [N-1:0] fire_w;
    wire [7:0] wtype = OD_WDATA_IN[7:0];
    wire type_ok = (wtype == tcp_pkg::TYPE_NEVER) || (wtype == tcp_pkg::TYPE_TIMER)
                   || ((wtype >= tcp_pkg::TYPE_SYNC_MIN) && (wtype <= tcp_pkg::TYPE_SYNC_MAX));

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_msg
            wire [31:0] load_val = use_default ?
                32'(tcp_pkg::COBID_DEF[gi] + 32'(node_sel)) : stored_w[gi]; // [RULE_06] [RULE_07] [RULE_08]
            wire [31:0] cob = cobid_r[gi];
            // upper id bits are dropped in base format
            wire [28:0] id_nxt = cob[tcp_pkg::BIT_EXT] ? cob[EW-1:0]
                                 : {18'h0_0000, cob[BW-1:0]}; // [RULE_05]

            assign hit_comm[gi] = (OD_INDEX_IN == 16'(tcp_pkg::IDX_COMM_BASE + 16'(gi)));
            assign hit_map[gi] = (OD_INDEX_IN == 16'(tcp_pkg::IDX_MAP_BASE + 16'(gi)));
            // bit 30 is stored as written; remote requests are never answered
            assign wr_cobid[gi] = od_take && OD_WR_IN && hit_comm[gi]
                                  && (OD_SUB_IN == tcp_pkg::SUB_COBID); // [RULE_03]
            assign wr_type[gi] = od_take && OD_WR_IN && hit_comm[gi]
                                 && (OD_SUB_IN == tcp_pkg::SUB_TYPE) && type_ok; // [RULE_13] [RULE_14]

            always_ff @(posedge CLOCK_IN) begin
                if (!RST_N_IN) begin
                    cobid_r[gi] <= tcp_pkg::COBID_DEF[gi];
                    type_r[gi] <= tcp_pkg::TYPE_DEF[gi]; // [RULE_12] [RULE_16] [RULE_17]
                    tx_id_r[gi] <= '0;
                    tx_ext_r[gi] <= 1'b0;
                end else begin
                    if (state_r == tcp_pkg::ST_LOAD) begin
                        cobid_r[gi] <= load_val; // [RULE_09] [RULE_10]
                    end else if (wr_cobid[gi]) begin
                        cobid_r[gi] <= OD_WDATA_IN;
                    end
                    if (wr_type[gi]) begin
                        type_r[gi] <= wtype;
                    end
                    tx_id_r[gi] <= id_nxt;
                    tx_ext_r[gi] <= cob[tcp_pkg::BIT_EXT]; // [RULE_04]
                end
            end

            tcp_trigger u_trig (
                .clk_in(CLOCK_IN),
                .rst_n_in(RST_N_IN),
                .sync_in(SYNC_RX_IN),
                .unit_tick_in(unit_tick_r),
                .type_in(type_r[gi]),
                .type_wr_in(wr_type[gi]),
                .cyc_time_in(CYCLIC_TIME_IN),
                .fire_out(fire_w[gi])
            );

            // gated after the trigger, so a disabled message keeps its sync count
            assign TX_REQ_OUT[gi] = fire_w[gi] && running
                                    && !cob[tcp_pkg::BIT_INVALID]; // [RULE_02]
        end
    endgenerate

    // ************************************************************
    // object access decode
    // ************************************************************
    logic [31:0] rdata_nxt;
    logic [31:0] code_nxt;
    logic abort_nxt;
    logic found;
    logic read_only;
    logic bad_type;

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        code_nxt = 32'h0000_0000;
        abort_nxt = 1'b0;
        found = 1'b0;
        read_only = 1'b0;
        bad_type = 1'b0;
        if (OD_INDEX_IN == tcp_pkg::IDX_IDENTITY) begin
            read_only = 1'b1;
            found = 1'b1;
            case (OD_SUB_IN)
                tcp_pkg::SUB_VENDOR: rdata_nxt = VENDOR_CODE; // [RULE_01]
                tcp_pkg::SUB_PRODUCT: rdata_nxt = PRODUCT_CODE; // [RULE_01]
                tcp_pkg::SUB_REVISION: rdata_nxt = REVISION_CODE; // [RULE_01]
                default: found = 1'b0;
            endcase
        end
        for (int i = 0; i < N; i++) begin
            if (hit_comm[i] && OD_SUB_IN == tcp_pkg::SUB_COBID) begin
                rdata_nxt = cobid_r[i];
                found = 1'b1;
            end
            if (hit_comm[i] && OD_SUB_IN == tcp_pkg::SUB_TYPE) begin
                rdata_nxt = {24'h00_0000, type_r[i]};
                found = 1'b1;
                bad_type = OD_WR_IN && !type_ok; // [RULE_14]
            end
            if (hit_map[i] && OD_SUB_IN == tcp_pkg::SUB_MAP1) begin
                rdata_nxt = tcp_pkg::MAP_POSITION; // [RULE_18]
                found = 1'b1;
                read_only = 1'b1;
            end
        end
        if (!found) begin
            abort_nxt = 1'b1;
            code_nxt = tcp_pkg::ABORT_NO_OBJECT;
        end else if (OD_WR_IN && read_only) begin
            abort_nxt = 1'b1;
            code_nxt = tcp_pkg::ABORT_READ_ONLY; // [RULE_01]
        end else if (bad_type) begin
            abort_nxt = 1'b1;
            code_nxt = tcp_pkg::ABORT_RANGE; // [RULE_14]
        end
        if (OD_WR_IN || abort_nxt) begin
            rdata_nxt = 32'h0000_0000;
        end
    end

    // ************************************************************
    // answer registers
    // ************************************************************
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            OD_ACK_OUT <= 1'b0;
            OD_ABORT_OUT <= 1'b0;
            OD_ABORT_CODE_OUT <= 32'h0000_0000;
            OD_RDATA_OUT <= 32'h0000_0000;
        end else begin
            OD_ACK_OUT <= od_take;
            OD_ABORT_OUT <= od_take && abort_nxt;
            OD_ABORT_CODE_OUT <= od_take ? code_nxt : 32'h0000_0000;
            OD_RDATA_OUT <= od_take ? rdata_nxt : 32'h0000_0000;
        end
    end

    assign OD_READY_OUT = running;
    assign TX_EXT_OUT = tx_ext_r;
    assign TX_MSG_TIMED_POSITION_ID_OUT = tx_id_r[0];
    assign TX_MSG_SYNC_POSITION_A_ID_OUT = tx_id_r[1];
    assign TX_MSG_SYNC_POSITION_B_ID_OUT = tx_id_r[2];

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    chk_absent_never_sent: assert property ( // [RULE_02]
        TX_REQ_OUT[2] |-> !cobid_r[2][tcp_pkg::BIT_INVALID] && running)
        else $error("absent message was requested");
    chk_base_upper_zero: assert property ( // [RULE_05]
        !TX_EXT_OUT[1] |-> TX_MSG_SYNC_POSITION_A_ID_OUT[28:11] == 18'h0_0000)
        else $error("base identifier carries upper bits");
    chk_range_abort_kept: assert property ( // [RULE_14]
        od_take && OD_WR_IN && hit_comm[1] && OD_SUB_IN == tcp_pkg::SUB_TYPE
        && wtype == 8'hff |=> OD_ABORT_OUT && OD_ABORT_CODE_OUT == 32'h0609_0030
        && $stable(type_r[1]))
        else $error("unsupported type not aborted or value changed");
    chk_type_zero_stored: assert property ( // [RULE_13]
        od_take && OD_WR_IN && hit_comm[1] && OD_SUB_IN == tcp_pkg::SUB_TYPE
        && wtype == 8'h00 |=> OD_ACK_OUT && !OD_ABORT_OUT && type_r[1] == 8'h00)
        else $error("type zero not accepted");
    chk_load_default: assert property ( // [RULE_09]
        state_r == tcp_pkg::ST_LOAD && sw_any
        |=> cobid_r[0] == 32'(32'h4000_0180 + 32'($past(sw_sync_r))))
        else $error("switch address did not force default identifier");
    chk_load_keep: assert property ( // [RULE_10]
        state_r == tcp_pkg::ST_LOAD && !sw_any && !ADDR_FORCE_IN
        |=> cobid_r[2] == $past(STORED_ID_SYNC_POSITION_B_IN))
        else $error("stored identifier not kept");
    chk_identity_read: assert property ( // [RULE_01]
        od_take && !OD_WR_IN && OD_INDEX_IN == 16'h1018 && OD_SUB_IN == 8'h01
        |=> OD_ACK_OUT && !OD_ABORT_OUT && OD_RDATA_OUT == VENDOR_CODE)
        else $error("vendor code read wrong");
    chk_map_default: assert property ( // [RULE_18]
        od_take && !OD_WR_IN && hit_map[1] && OD_SUB_IN == tcp_pkg::SUB_MAP1
        |=> OD_RDATA_OUT == 32'h6004_0020)
        else $error("mapping default read wrong");
    // the map entries are fixed in this block, so a write must bounce
    chk_map_read_only: assert property ( // [RULE_18]
        od_take && OD_WR_IN && hit_map[0] && OD_SUB_IN == tcp_pkg::SUB_MAP1
        |=> OD_ABORT_OUT && OD_ABORT_CODE_OUT == tcp_pkg::ABORT_READ_ONLY)
        else $error("mapping entry accepted a write");
    chk_identity_ro: assert property ( // [RULE_01]
        od_take && OD_WR_IN && OD_INDEX_IN == 16'h1018 && OD_SUB_IN == 8'h01
        |=> OD_ABORT_OUT && OD_ABORT_CODE_OUT == tcp_pkg::ABORT_READ_ONLY)
        else $error("identity entry accepted a write");
    // running implies the previous edge was out of reset, so the past value is clean
    chk_low_id_bits: assert property ( // [RULE_05]
        running |-> TX_MSG_TIMED_POSITION_ID_OUT[10:0] == $past(cobid_r[0][10:0]))
        else $error("identifier low bits wrong");
    chk_sync_after_sync: assert property ( // [RULE_11]
        TX_REQ_OUT[1] && type_r[1] != tcp_pkg::TYPE_TIMER |-> $past(SYNC_RX_IN))
        else $error("sync message sent without a sync frame");
    chk_timer_on_tick: assert property ( // [RULE_15]
        TX_REQ_OUT[0] && type_r[0] == tcp_pkg::TYPE_TIMER
        |-> $past(unit_tick_r) && $past(CYCLIC_TIME_IN) != '0)
        else $error("timed message sent off a tick");

    cov_sync_send: cover property (TX_REQ_OUT[1]);
    cov_timed_send: cover property (TX_REQ_OUT[0]);
    cov_range_abort: cover property (OD_ABORT_OUT && OD_ABORT_CODE_OUT == tcp_pkg::ABORT_RANGE);
    cov_switch_load: cover property (state_r == tcp_pkg::ST_LOAD && sw_any);
    cov_ext_send: cover property (TX_REQ_OUT[2] && TX_EXT_OUT[2]);

endmodule

// ===== hdl/tcp_trigger.sv
/*
 * one trigger unit: sync counter and cyclic timer for one message.
 * assumes sync and unit-tick pulses from logic on the same clock.
 */
`timescale 1ns/1ps
module tcp_trigger (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic sync_in,
    input wire logic unit_tick_in,
    input wire logic [7:0] type_in,
    input wire logic type_wr_in,
    input wire logic [tcp_pkg::CYC_W-1:0] cyc_time_in,
    output logic fire_out
);

    // ************************************************************
    // mode decode
    // ************************************************************
    localparam int CYC_W = tcp_pkg::CYC_W;
    logic [7:0] sync_cnt_r;
    logic [7:0] sync_cnt_nxt;
    logic [tcp_pkg::CYC_W-1:0] tmr_cnt_r;
    logic [tcp_pkg::CYC_W-1:0] tmr_cnt_nxt;
    logic fire_r;
    wire is_sync = (type_in >= tcp_pkg::TYPE_SYNC_MIN) && (type_in <= tcp_pkg::TYPE_SYNC_MAX);
    wire is_timer = (type_in == tcp_pkg::TYPE_TIMER);
    wire sync_due = is_sync && sync_in && (8'(sync_cnt_r + 8'h01) >= type_in); // [RULE_11]
    // a zero interval never expires, so nothing is sent
    wire tmr_due = is_timer && (cyc_time_in != '0) && unit_tick_in
                   && (CYC_W'(tmr_cnt_r + 1'b1) >= cyc_time_in); // [RULE_12] [RULE_15]

    // restart on rewrite so the new count applies from the next sync
    assign sync_cnt_nxt = (type_wr_in || !is_sync) ? 8'h00 :
                          sync_due ? 8'h00 :
                          sync_in ? 8'(sync_cnt_r + 8'h01) : sync_cnt_r; // [RULE_19]
    assign tmr_cnt_nxt = (type_wr_in || !is_timer || cyc_time_in == '0) ? '0 :
                         tmr_due ? '0 :
                         unit_tick_in ? CYC_W'(tmr_cnt_r + 1'b1) : tmr_cnt_r;

    // ************************************************************
    // counters
    // ************************************************************
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sync_cnt_r <= 8'h00;
            tmr_cnt_r <= '0;
            fire_r <= 1'b0;
        end else begin
            sync_cnt_r <= sync_cnt_nxt;
            tmr_cnt_r <= tmr_cnt_nxt;
            // type zero decodes to neither mode, so it never fires
            fire_r <= !type_wr_in && (sync_due || tmr_due); // [RULE_13]
        end
    end

    assign fire_out = fire_r;

    // ************************************************************
    // checks
    // ************************************************************
    chk_type_zero_silent: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_13]
        (type_in == tcp_pkg::TYPE_NEVER) && $past(type_in == tcp_pkg::TYPE_NEVER) |-> !fire_r)
        else $error("type zero produced a transmission");
    chk_sync_every_one: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_11]
        (type_in == tcp_pkg::TYPE_SYNC_MIN) && sync_in && !type_wr_in |=> fire_r)
        else $error("type one missed a sync");
    chk_cyc_zero_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_15]
        is_timer && (cyc_time_in == '0) && $past(cyc_time_in == '0) && $past(is_timer)
        |-> !fire_r)
        else $error("timer fired with zero interval");
    chk_rewrite_restart: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_19]
        type_wr_in |=> (sync_cnt_r == 8'h00) && (tmr_cnt_r == '0))
        else $error("counter not restarted on type write");

endmodule

// ===== sim/tcp_sync_master.sv
/*
 * network master stand-in: sends sync frames, one every 8 cycles.
 * assumes the bench raises en_in just after an edge and holds it
 * for a whole number of 8-cycle slots.
 */
`timescale 1ns/1ps
module tcp_sync_master (
    input wire logic clk_in,
    input wire logic en_in,
    output logic sync_out
);
    logic [2:0] cnt_r;
    // the line idles low between frames, so no stray sync is seen
    always_ff @(posedge clk_in) begin
        cnt_r <= en_in ? cnt_r + 3'h1 : 3'h0;
    end
    assign sync_out = en_in & (cnt_r == 3'h7);
endmodule

// ===== sim/testbench.sv
/*
 * self-checking bench: object reads/writes, sync and timer sends.
 * assumes the design answers one cycle after each taken request.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench;
    logic clk = 0, rst_n = 0, req = 0, wr = 0, sync_en = 0, frc = 0;
    logic [6:0] sw = 7'h05, nid = 7'h11;
    logic [15:0] idx = 0, cyc = 0;
    logic [7:0] sub = 0;
    logic [31:0] wd = 0, st = 32'h4000_0123, w;
    wire sync, rdy, ack, ab;
    wire [31:0] code, rd;
    wire [2:0] txr, ext;
    wire [28:0] id0, id1, id2;
    int n_errors = 0, n_checks = 0, ncy = 0, t0;
    int fires[3];
    logic [7:0] bad_ty[5] = '{8'hf1, 8'hfb, 8'hfc, 8'hfd, 8'hff};
    logic [64:0] q[$];
    always #2.5 clk = ~clk;
    tcp_sync_master M (.clk_in(clk), .en_in(sync_en), .sync_out(sync));
    tcp_top #(.CYC_UNIT_CYCLES(10)) DUT (.CLOCK_IN(clk), .RST_N_IN(rst_n),
        .NODE_SW_IN(sw), .NODE_ID_IN(nid), .ADDR_FORCE_IN(frc),
        .STORED_ID_TIMED_POSITION_IN(st), .STORED_ID_SYNC_POSITION_A_IN(st),
        .STORED_ID_SYNC_POSITION_B_IN(st), .SYNC_RX_IN(sync),
        .CYCLIC_TIME_IN(cyc), .OD_REQ_IN(req), .OD_WR_IN(wr),
        .OD_INDEX_IN(idx), .OD_SUB_IN(sub), .OD_WDATA_IN(wd),
        .OD_READY_OUT(rdy), .OD_ACK_OUT(ack), .OD_ABORT_OUT(ab),
        .OD_ABORT_CODE_OUT(code), .OD_RDATA_OUT(rd), .TX_REQ_OUT(txr),
        .TX_EXT_OUT(ext), .TX_MSG_TIMED_POSITION_ID_OUT(id0),
        .TX_MSG_SYNC_POSITION_A_ID_OUT(id1), .TX_MSG_SYNC_POSITION_B_ID_OUT(id2));
    // ************************************************************
    // monitor: oldest note is matched against each answer
    // ************************************************************
    always @(posedge clk) begin
        ncy++;
        for (int i = 0; i < 3; i++) if (txr[i] === 1'b1) fires[i]++;
        if (ack === 1'b1) `CHK("answer", q.pop_front(), {ab, code, rd})
    end
    task automatic od(input logic w_i, input [15:0] i, input [7:0] s,
                      input [31:0] d, input [64:0] e);
        @(posedge clk) #1;
        req = 1; wr = w_i; idx = i; sub = s; wd = d;
        q.push_back(e);
        @(posedge clk) #1 req = 0;
    endtask
    task automatic rst();
        #1 rst_n = 0;
        repeat (5) @(posedge clk);
        `CHK("ready low", 1'b0, rdy)
        #1 rst_n = 1;
        repeat (6) @(posedge clk);
        `CHK("ready", 1'b1, rdy)
    endtask
    task automatic syncs(input int k);
        fires = '{0, 0, 0};
        @(posedge clk) #1 sync_en = 1;
        repeat (8 * k) @(posedge clk);
        #1 sync_en = 0;
        repeat (4) @(posedge clk);
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #300000;
        n_errors++;
        summarize();
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        void'($urandom(20004));
        nid = 7'($urandom % 127 + 1);
        bad_ty[0] = 8'hf1 + 8'($urandom % 11);
        rst();
        od(0, 16'h1018, 8'h01, 0, {33'h0, 32'h0000_5a5a});
        od(0, 16'h1018, 8'h02, 0, {33'h0, 32'h0000_0a11});
        od(0, 16'h1018, 8'h03, 0, {33'h0, 32'h0000_0003});
        od(1, 16'h1018, 8'h01, 0, {1'b1, 32'h0601_0002, 32'h0});
        od(0, 16'h2000, 8'h01, 0, {1'b1, 32'h0602_0000, 32'h0});
        od(0, 16'h1800, 8'h01, 0, {33'h0, 32'h4000_0185});
        od(0, 16'h1801, 8'h01, 0, {33'h0, 32'h4000_0285});
        od(0, 16'h1802, 8'h01, 0, {33'h0, 32'hc000_0385});
        od(0, 16'h1800, 8'h02, 0, {33'h0, 32'h0000_00fe});
        od(0, 16'h1801, 8'h02, 0, {33'h0, 32'h0000_0001});
        for (int i = 0; i < 3; i++)
            od(0, 16'h1a00 + 16'(i), 8'h01, 0, {33'h0, 32'h6004_0020});
        od(1, 16'h1a00, 8'h01, 0, {1'b1, 32'h0601_0002, 32'h0});
        foreach (bad_ty[j])
            od(1, 16'h1801, 8'h02, {24'h0, bad_ty[j]}, {1'b1, 32'h0609_0030, 32'h0});
        od(0, 16'h1801, 8'h02, 0, {33'h0, 32'h0000_0001});
        syncs(6);
        `CHK("sync a", 6, fires[1])
        `CHK("sync b off", 0, fires[2])
        `CHK("timer idle", 0, fires[0])
        od(1, 16'h1801, 8'h02, 32'h0000_0003, 65'h0);
        syncs(6);
        `CHK("sync a n3", 2, fires[1])
        od(1, 16'h1801, 8'h02, 32'h0000_0000, 65'h0);
        w = 32'h6000_0000 | ($urandom & 32'h1fff_ffff); // bit 30 kept set
        od(1, 16'h1802, 8'h01, w, 65'h0);
        od(1, 16'h1801, 8'h01, 32'h4000_0000 | ($urandom & 32'h0000_07ff), 65'h0);
        syncs(3);
        `CHK("type zero", 0, fires[1])
        `CHK("sync b on", 3, fires[2])
        `CHK("ext flags", 3'b100, ext)
        `CHK("ext id", w[28:0], id2)
        `CHK("base id", {18'h0, wd[10:0]}, id1)
        `CHK("timed id", 29'h185, id0)
        // timer interval is measured pulse to pulse, so phase does not matter
        #1 cyc = 16'h0003;
        for (int k = 0; k < 2; k++) begin
            t0 = ncy;
            for (int c = 0; c < 100 && txr[0] !== 1'b1; c++) @(posedge clk);
            @(posedge clk) #1;
        end
        `CHK("timer gap", 30, ncy - t0)
        cyc = 0;
        sw = 0;
        rst();
        od(0, 16'h1800, 8'h01, 0, {33'h0, st});
        frc = 1;
        rst();
        od(0, 16'h1800, 8'h01, 0, {33'h0, 32'h4000_0180 + 32'(nid)});
        repeat (3) @(posedge clk);
        `CHK("all answered", 0, q.size())
        summarize();
    end
endmodule
